// ===== port1_pin_mode_config_test.sv
// self-checking bench for the pin mode configuration register
// assumes ppmc_pkg, ppmc_top and ppmc_apb_master are compiled first
`timescale 1ns/1ns
`default_nettype none
module port1_pin_mode_config_test;
  logic pclk = 0;
  logic presetn = 0;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  ppmc_pkg::ppmc_pad_t pad [ppmc_pkg::num_pins];
  logic [2:0] out_m [8];
  logic [1:0] in_m [8];
  logic [1:0] var_m;
  logic [31:0] r;
  logic e, dir;
  logic [2:0] i, fn;
  integer seed = 32'h539583e0;
  int fails = 0;
  int samples_checked = 0;
  ppmc_top ppmc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad(pad));
  ppmc_apb_master ppmc_apb_master_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #10 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] exp_rd(input logic [2:0] k, input logic d);
    return d ? {24'h0, 1'b0, in_m[k], 5'h0} : {24'h0, out_m[k], 5'h0};
  endfunction
  function automatic logic ok_idx(input logic [2:0] k);
    return !(var_m == ppmc_pkg::var_small || (var_m == ppmc_pkg::var_middle && k == 3'h7));
  endfunction
  task automatic wr(input logic [7:0] b);
    ppmc_apb_master_i.xfer(1, ppmc_pkg::port1_pin_config_byte[11:0], {24'h0, b}, r, e);
    check(e, 0);
    if (!b[3] && ok_idx(b[2:0])) begin
      if (b[4]) in_m[b[2:0]] = b[6:5];
      else out_m[b[2:0]] = b[7:5];
    end
  endtask
  // pads follow the config flops, so look away from the edge that loads them
  task automatic chk_all();
    @(negedge pclk);
    for (int k = 0; k < 8; k++) begin
      check(pad[k], {out_m[k] == 3'h3, in_m[k] == 2'h1, in_m[k] == 2'h2, in_m[k] != 2'h3});
    end
  endtask
  task automatic do_reset();
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    var_m = ppmc_pkg::var_large;
    for (int k = 0; k < 8; k++) begin
      out_m[k] = 3'h0;
      in_m[k] = 2'h0;
    end
    chk_all();
    ppmc_apb_master_i.xfer(0, ppmc_pkg::port1_pin_config_byte[11:0], 32'h0, r, e);
    check(r, 32'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    do_reset();
    $display("test reset done");
    ppmc_apb_master_i.xfer(1, 12'h0a0, 32'hff, r, e);
    check(e, 1);
    ppmc_apb_master_i.xfer(0, 12'h0a0, 32'h0, r, e);
    check(e, 1);
    chk_all();
    $display("test unmapped done");
    for (int n = 0; n < 240; n++) begin
      if (n % 40 == 0) begin
        var_m = 2'($unsigned($random(seed)) % 3);
        ppmc_apb_master_i.xfer(1, ppmc_pkg::variant_addr, {30'h0, var_m}, r, e);
        ppmc_apb_master_i.xfer(0, ppmc_pkg::variant_addr, 32'h0, r, e);
        check(r, {30'h0, var_m});
      end
      i = 3'($random(seed));
      dir = 1'($random(seed));
      fn = 3'($random(seed));
      if (!dir) fn = fn[0] ? ppmc_pkg::out_high : ppmc_pkg::out_normal;
      wr({fn, dir, 1'b0, i});
      chk_all();
      i = 3'($random(seed));
      dir = 1'($random(seed));
      wr({3'($random(seed)), dir, 1'b1, i});
      chk_all();
      ppmc_apb_master_i.xfer(0, ppmc_pkg::port1_pin_config_byte[11:0], 32'h0, r, e);
      if (ok_idx(i)) check(r, exp_rd(i, dir));
      if (n == 120) do_reset();
    end
    $display("test random done");
    wrap_up();
  end
endmodule // port1_pin_mode_config_test
`default_nettype wire

// ===== ppmc_apb_master.sv
// apb master standing in for the processor core
// assumes the slave samples on pclk rising edges
`timescale 1ns/1ns
`default_nettype none
module ppmc_apb_master (
  // clock
  input wire logic pclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // released address and data lines show the inverse so a stale value never looks valid
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // ppmc_apb_master
`default_nettype wire

// ===== ppmc_cell.sv
// one pin's output and input configuration storage
// assumes writes are already decoded for this pin by ppmc_top
`timescale 1ns/1ns
`default_nettype none
module ppmc_cell (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write strobes
  input wire logic wr_out,
  input wire logic wr_in,
  input wire logic [2:0] fn,
  // stored modes
  output logic [2:0] out_mode,
  output logic [1:0] in_mode
);
  logic [2:0] next_out_mode;
  logic [1:0] next_in_mode;
  always_comb begin
    next_out_mode = out_mode;
    next_in_mode = in_mode;
    if (wr_out) begin
      next_out_mode = fn;
    end
    if (wr_in) begin
      next_in_mode = fn[1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_mode <= ppmc_pkg::cfg_reset[2:0];
      in_mode <= ppmc_pkg::cfg_reset[1:0];
    end else begin
      out_mode <= next_out_mode;
      in_mode <= next_in_mode;
    end
  end
endmodule // ppmc_cell
`default_nettype wire

// ===== ppmc_pkg.sv
// package of constants and types for the port1 pin mode configuration block
// assumes an apb slave wrapper in ppmc_top and one config cell per pin
//
// Contract
// - output function 000 is normal drive, 011 is high drive.
// - input uses bits 6:5: none, pull-down, pull-up, buffer off.
// - direction bit 0 targets output config, 1 targets input config.
// - address-latch write stores index and direction, no config change.
// - non-latch write loads function code into indexed pin config.
// - read returns latched pin's mode for latched direction.
// - pin index selects pins 0 to 7 by binary value.
// - package variant reserves index 111 (middle) or all (smallest).
package ppmc_pkg;
  // ***************
  // register map
  // ***************
  localparam logic [11:0] port1_pin_config_addr = 12'h09f;
  localparam logic [31:0] port1_pin_config_byte = 32'h0000027c;
  localparam logic [11:0] variant_addr = 12'h100;
  localparam logic [7:0] cfg_reset = 8'h00;
  localparam int unsigned num_pins = 8;
  // ***************
  // fields
  // ***************
  localparam int unsigned fn_hi = 7;
  localparam int unsigned fn_lo = 5;
  localparam int unsigned dir_bit = 4;
  localparam int unsigned latch_bit = 3;
  localparam int unsigned idx_hi = 2;
  localparam logic [2:0] out_normal = 3'h0;
  localparam logic [2:0] out_high = 3'h3;
  localparam logic [1:0] in_nopull = 2'h0;
  localparam logic [1:0] in_pulldown = 2'h1;
  localparam logic [1:0] in_pullup = 2'h2;
  localparam logic [1:0] in_off = 2'h3;
  localparam logic [2:0] idx_top = 3'h7;
  // package variants
  localparam logic [1:0] var_large = 2'h0;
  localparam logic [1:0] var_middle = 2'h1;
  localparam logic [1:0] var_small = 2'h2;
  typedef struct packed {
    logic high_drive;
    logic pull_down;
    logic pull_up;
    logic in_buf_en;
  } ppmc_pad_t;
endpackage

// ===== ppmc_top.sv
// apb slave holding the port1 pin configuration register and pad controls
// assumes a single apb master on pclk; pad controls go to the port pads
`timescale 1ns/1ns
`default_nettype none
module ppmc_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pad controls
  output ppmc_pkg::ppmc_pad_t pad [ppmc_pkg::num_pins]
);
  // ***************
  // bus decode
  // ***************
  logic acc;
  logic commit;
  logic hit_cfg;
  logic hit_var;
  logic wr_cfg;
  logic wr_var;
  logic [7:0] wbyte;
  logic [2:0] lat_idx;
  logic lat_dir;
  logic [1:0] variant;
  logic [2:0] next_lat_idx;
  logic next_lat_dir;
  logic [1:0] next_variant;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [2:0] out_mode [ppmc_pkg::num_pins];
  logic [1:0] in_mode [ppmc_pkg::num_pins];
  logic [ppmc_pkg::num_pins-1:0] wr_out;
  logic [ppmc_pkg::num_pins-1:0] wr_in;
  logic idx_ok;
  logic [7:0] rd_cfg;
  logic [2:0] w_idx;
  logic [2:0] w_fn;

  // read data and error load at setup so they stand through the access phase
  assign acc = psel && !penable;
  assign pready = 1'b1;
  // config, latch and variant state change only at the completing edge of the access phase
  assign commit = psel && penable && pready;
  assign wbyte = pwdata[7:0];
  assign w_idx = wbyte[ppmc_pkg::idx_hi:0];
  assign w_fn = wbyte[ppmc_pkg::fn_hi:ppmc_pkg::fn_lo];
  always_comb begin
    hit_cfg = 1'b0;
    hit_var = 1'b0;
    // odd register index, so the bus sees it as a word at four times that
    if (paddr == ppmc_pkg::port1_pin_config_byte[11:0]) begin
      hit_cfg = 1'b1;
    end else if (paddr == ppmc_pkg::variant_addr) begin
      hit_var = 1'b1;
    end
  end
  // zero wait states, so a write lands one edge after its setup edge
  assign wr_cfg = commit && pwrite && hit_cfg;
  assign wr_var = commit && pwrite && hit_var;

  always_comb begin
    case (variant)
      ppmc_pkg::var_large: idx_ok = 1'b1;
      ppmc_pkg::var_middle: idx_ok = (wbyte[ppmc_pkg::idx_hi:0] != ppmc_pkg::idx_top);
      default: idx_ok = 1'b0;
    endcase
  end

  // ***************
  // pin writes
  // ***************
  always_comb begin
    wr_out = '0;
    wr_in = '0;
    if (wr_cfg && !wbyte[ppmc_pkg::latch_bit] && idx_ok) begin
      if (wbyte[ppmc_pkg::dir_bit]) begin
        wr_in[wbyte[ppmc_pkg::idx_hi:0]] = 1'b1;
      end else begin
        wr_out[wbyte[ppmc_pkg::idx_hi:0]] = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < ppmc_pkg::num_pins; g++) begin : g_pin
      ppmc_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .wr_out(wr_out[g]),
        .wr_in(wr_in[g]),
        .fn(wbyte[ppmc_pkg::fn_hi:ppmc_pkg::fn_lo]),
        .out_mode(out_mode[g]),
        .in_mode(in_mode[g])
      );
      assign pad[g] = '{
        high_drive: (out_mode[g] == ppmc_pkg::out_high),
        pull_down: (in_mode[g] == ppmc_pkg::in_pulldown),
        pull_up: (in_mode[g] == ppmc_pkg::in_pullup),
        in_buf_en: (in_mode[g] != ppmc_pkg::in_off)
      };
    end
  endgenerate

  // ***************
  // latch and read
  // ***************
  always_comb begin
    next_lat_idx = lat_idx;
    next_lat_dir = lat_dir;
    next_variant = variant;
    if (wr_cfg && wbyte[ppmc_pkg::latch_bit]) begin
      next_lat_idx = wbyte[ppmc_pkg::idx_hi:0];
      next_lat_dir = wbyte[ppmc_pkg::dir_bit];
    end
    if (wr_var) begin
      next_variant = pwdata[1:0];
    end
  end

  always_comb begin
    rd_cfg = ppmc_pkg::cfg_reset;
    if (lat_dir) begin
      rd_cfg[ppmc_pkg::fn_lo +: 2] = in_mode[lat_idx];
    end else begin
      rd_cfg[ppmc_pkg::fn_hi:ppmc_pkg::fn_lo] = out_mode[lat_idx];
    end
  end

  always_comb begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (acc) begin
      if (hit_cfg) begin
        next_prdata = {24'h000000, rd_cfg};
      end else if (hit_var) begin
        next_prdata = {30'h00000000, variant};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_idx <= ppmc_pkg::cfg_reset[ppmc_pkg::idx_hi:0];
      lat_dir <= ppmc_pkg::cfg_reset[ppmc_pkg::dir_bit];
      variant <= ppmc_pkg::var_large;
      prdata <= {24'h000000, ppmc_pkg::cfg_reset};
      pslverr <= 1'b0;
    end else begin
      lat_idx <= next_lat_idx;
      lat_dir <= next_lat_dir;
      variant <= next_variant;
      prdata <= acc ? next_prdata : prdata;
      pslverr <= acc ? next_pslverr : pslverr;
    end
  end

  // ***************
  // checks
  // ***************
  // software first latches a pin, or loads one; both steps land at commit
  sequence s_latch_wr;
    wr_cfg && wbyte[ppmc_pkg::latch_bit];
  endsequence
  sequence s_load_wr;
    wr_cfg && !wbyte[ppmc_pkg::latch_bit] && variant == ppmc_pkg::var_large;
  endsequence
  a_latch_no_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    s_latch_wr |-> (wr_out == '0) && (wr_in == '0)) else $error("latch write changed config");
  a_latch_stores: assert property (@(posedge pclk) disable iff (!presetn)
    s_latch_wr |=> lat_idx == $past(w_idx) && lat_dir == $past(wbyte[ppmc_pkg::dir_bit])) else $error("latch not stored");
  a_latch_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_cfg && wbyte[ppmc_pkg::latch_bit]) |=> lat_idx == $past(lat_idx) && lat_dir == $past(lat_dir))
    else $error("latch moved without latch write");
  a_out_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_load_wr ##0 !wbyte[ppmc_pkg::dir_bit] |=> out_mode[$past(w_idx)] == $past(w_fn))
    else $error("output config not loaded");
  a_in_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_load_wr ##0 wbyte[ppmc_pkg::dir_bit] |=> in_mode[$past(w_idx)] == $past(w_fn[1:0]))
    else $error("input config not loaded");
  a_no_load: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cfg |-> (wr_out == '0) && (wr_in == '0)) else $error("config written without access");
  a_read_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && hit_cfg && !lat_dir) |=> prdata[ppmc_pkg::fn_hi:ppmc_pkg::fn_lo] == out_mode[lat_idx])
    else $error("read mode wrong");
  a_read_in: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && hit_cfg && lat_dir) |=> prdata[ppmc_pkg::fn_hi:ppmc_pkg::fn_lo] == {1'b0, in_mode[lat_idx]})
    else $error("read input mode wrong");
  a_high_drive: assert property (@(posedge pclk) disable iff (!presetn)
    pad[0].high_drive == (out_mode[0] == ppmc_pkg::out_high)) else $error("drive decode wrong");
  a_buf_off: assert property (@(posedge pclk) disable iff (!presetn)
    pad[1].in_buf_en == (in_mode[1] != ppmc_pkg::in_off)) else $error("buffer decode wrong");
  a_pull_up: assert property (@(posedge pclk) disable iff (!presetn)
    pad[2].pull_up == (in_mode[2] == ppmc_pkg::in_pullup)) else $error("pull-up decode wrong");
  a_pull_down: assert property (@(posedge pclk) disable iff (!presetn)
    pad[4].pull_down == (in_mode[4] == ppmc_pkg::in_pulldown)) else $error("pull-down decode wrong");
  a_small_none: assert property (@(posedge pclk) disable iff (!presetn)
    (variant == ppmc_pkg::var_small) |-> (wr_out == '0) && (wr_in == '0)) else $error("reserved pin written");
  a_middle_top: assert property (@(posedge pclk) disable iff (!presetn)
    (variant == ppmc_pkg::var_middle) |-> !wr_out[ppmc_pkg::idx_top] && !wr_in[ppmc_pkg::idx_top])
    else $error("reserved top pin written");
  a_idx_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_out != '0) |-> wr_out == (8'h01 << w_idx)) else $error("index decode wrong");
  a_idx_in: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_in != '0) |-> wr_in == (8'h01 << w_idx)) else $error("input index decode wrong");
  // pin 5 must keep its output code in every cycle its wr_out strobe is low
  a_cell_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_out[5] |=> out_mode[5] == $past(out_mode[5])) else $error("unwritten pin changed");
endmodule // ppmc_top
`default_nettype wire
